/* rtl/event_signal_defines.vh */
// constants for the general purpose event signalling block
// assumes a 32-bit axi4-lite register bus with 12-bit byte addresses
`ifndef EVENT_SIGNAL_DEFINES_VH
`define EVENT_SIGNAL_DEFINES_VH

`define ADDR_W 12
`define DATA_W 32
`define PORT_HI 7
`define PORT_LO 1

// register byte addresses
`define OFS_DIVERT_CTRL 12'h450
`define OFS_PENDING_STS 12'h454
`define OFS_PIN_CFG 12'h458
`define OFS_IRQ_STATUS 12'h45c
`define OFS_IRQ_MASK 12'h460

// field positions
`define BIT_POL_INVERT 0
`define BIT_ALT_ENABLE 0
`define FLD_PORT_HI 7
`define FLD_PORT_LO 1
`define BIT_LANE_FIELDS 0

// reset values
`define RST_DIVERT_CTRL 8'h00
`define RST_PIN_CFG 1'h0
`define RST_IRQ_STATUS 7'h00
`define RST_IRQ_MASK 7'h00

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO_WORD 32'h00000000

`endif

/* rtl/event_port_slice.v */
// one downstream port: steers its notification to the standard path or the event pin
// assumes the port request comes from core logic on aclk
`timescale 1ns/1ps
module event_port_slice (
   input wire aclk,
   input wire aresetn,
   input wire event_req,
   input wire divert_enable,
   output wire std_notify,
   output wire pending,
   output wire pending_rise
);
   reg pending_reg;
   reg pending_next;

   // standard intx, msi and pme path is blocked while diverted
   assign std_notify = event_req & ~divert_enable;

   always @* begin
      pending_next = event_req & divert_enable;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         pending_reg <= 1'b0;
      end else begin
         pending_reg <= pending_next;
      end
   end

   assign pending = pending_reg;
   // pending clears at the edge after the enable drops; the rise is taken from pending_next, a cycle ahead of pending
   assign pending_rise = pending_next & ~pending_reg;
endmodule // event_port_slice

/* rtl/event_pin_driver.v */
// drives the event level onto the shared general purpose pin
// assumes the pin pad resolves level from out and oe
`timescale 1ns/1ps
module event_pin_driver (
   input wire aclk,
   input wire aresetn,
   input wire event_active,
   input wire polarity_invert,
   input wire alt_enable,
   output wire pin_out,
   output wire pin_oe
);
   reg out_reg;
   reg oe_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         // 0: active low, 1: active high
         out_reg <= alt_enable & (polarity_invert ? event_active : ~event_active);
         oe_reg <= alt_enable;
      end
   end

   assign pin_out = out_reg;
   assign pin_oe = oe_reg;
endmodule // event_pin_driver

/* rtl/event_signal_top.v */
// general purpose event signalling for downstream ports 1 to 7
// assumes port requests come from core logic on aclk and aresetn is the fundamental reset
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "event_signal_defines.vh"

module event_signal_top (
   input wire aclk,
   input wire aresetn,
   input wire hot_reset,
   input wire [`PORT_HI:`PORT_LO] port_event_req,
   output wire [`PORT_HI:`PORT_LO] std_notify,
   output wire gpio7_out,
   output wire gpio7_oe,
   output wire irq,
   input wire [`ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [`DATA_W-1:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [`DATA_W-1:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready
);
   // sticky configuration
   reg [`PORT_HI:0] divert_ctrl_reg;
   reg alt_enable_reg;
   // interrupt block
   reg [`PORT_HI:`PORT_LO] irq_status_reg;
   reg [`PORT_HI:`PORT_LO] irq_status_next;
   reg [`PORT_HI:`PORT_LO] irq_mask_reg;
   reg irq_reg;

   // write channel holding
   reg aw_full_reg;
   reg [`ADDR_W-1:0] aw_addr_reg;
   reg w_full_reg;
   reg [`DATA_W-1:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   // read channel
   reg rvalid_reg;
   reg [`DATA_W-1:0] rdata_reg;
   reg [1:0] rresp_reg;
   reg [`DATA_W-1:0] rd_word;
   reg [`PORT_HI:`PORT_LO] irq_mask_next;
   reg [`DATA_W-1:0] ctrl_word;
   reg [`DATA_W-1:0] pend_word;
   reg [`DATA_W-1:0] pin_word;
   reg [`DATA_W-1:0] stat_word;
   reg [`DATA_W-1:0] mask_word;

   wire [`PORT_HI:`PORT_LO] pending;
   wire [`PORT_HI:`PORT_LO] pending_rise;
   wire event_active;
   wire wr_go;
   wire ar_hs;
   wire [`PORT_HI:`PORT_LO] w1c_bits;
   wire lane_wr;
   wire wr_ctrl;
   wire wr_pin;
   wire wr_stat;
   wire wr_mask;
   wire rd_ok;

   // true when the address hits one of the mapped words
   function addr_mapped;
      input [`ADDR_W-1:0] a;
      begin
         addr_mapped = (a == `OFS_DIVERT_CTRL) || (a == `OFS_PENDING_STS) || (a == `OFS_PIN_CFG)
            || (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_MASK);
      end
   endfunction

   // pending status is read-only, writes there are accepted and dropped
   function addr_writable;
      input [`ADDR_W-1:0] a;
      begin
         addr_writable = (a == `OFS_DIVERT_CTRL) || (a == `OFS_PIN_CFG)
            || (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_MASK);
      end
   endfunction

   // address compare shared by the write strobes
   function addr_is;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] ofs;
      begin
         addr_is = (a == ofs);
      end
   endfunction

   // per-port steering
   genvar p;
   generate
      for (p = `PORT_LO; p <= `PORT_HI; p = p + 1) begin : g_port
         event_port_slice u_slice (
            .aclk(aclk),
            .aresetn(aresetn),
            .event_req(port_event_req[p]),
            .divert_enable(divert_ctrl_reg[p]),
            .std_notify(std_notify[p]),
            .pending(pending[p]),
            .pending_rise(pending_rise[p])
         );
      end
   endgenerate

   // any diverted port asserting drives the shared pin
   assign event_active = |pending;

   event_pin_driver u_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .event_active(event_active),
      .polarity_invert(divert_ctrl_reg[`BIT_POL_INVERT]),
      .alt_enable(alt_enable_reg),
      .pin_out(gpio7_out),
      .pin_oe(gpio7_oe)
   );

   // ---------------- write path ----------------
   assign s_axi_awready = ~aw_full_reg;
   assign s_axi_wready = ~w_full_reg;
   // no new write runs while the last response still waits for bready
   assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;

   // address and data are held apart so either may arrive first
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= {`ADDR_W{1'b0}};
      end else if (s_axi_awvalid && !aw_full_reg) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_full_reg <= 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg <= 1'b0;
         w_data_reg <= `ZERO_WORD;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && !w_full_reg) begin
         w_full_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
         w_full_reg <= 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= addr_mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // byte lane 0 carries every live field, the other lanes are ignored
   assign lane_wr = wr_go & w_strb_reg[`BIT_LANE_FIELDS];
   assign wr_ctrl = lane_wr & addr_is(aw_addr_reg, `OFS_DIVERT_CTRL);
   assign wr_pin = lane_wr & addr_is(aw_addr_reg, `OFS_PIN_CFG);
   assign wr_stat = lane_wr & addr_is(aw_addr_reg, `OFS_IRQ_STATUS);
   assign wr_mask = lane_wr & addr_is(aw_addr_reg, `OFS_IRQ_MASK);
   assign w1c_bits = wr_stat ? w_data_reg[`FLD_PORT_HI:`FLD_PORT_LO] : {(`PORT_HI-`PORT_LO+1){1'b0}};

   // sticky bits: only the fundamental reset clears them, hot reset leaves them
   always @(posedge aclk) begin
      if (!aresetn) begin
         divert_ctrl_reg <= `RST_DIVERT_CTRL;
         alt_enable_reg <= `RST_PIN_CFG;
      end else if (lane_wr && addr_writable(aw_addr_reg)) begin
         if (wr_ctrl) begin
            divert_ctrl_reg <= w_data_reg[`PORT_HI:0];
         end
         if (wr_pin) begin
            alt_enable_reg <= w_data_reg[`BIT_ALT_ENABLE];
         end
      end
   end

   // ---------------- interrupts ----------------
   always @* begin
      // a new event wins over a clear in the same cycle
      irq_status_next = (irq_status_reg & ~w1c_bits) | pending_rise;
   end

   always @* begin
      irq_mask_next = irq_mask_reg;
      if (wr_mask) begin
         irq_mask_next = w_data_reg[`FLD_PORT_HI:`FLD_PORT_LO];
      end
   end

   // hot reset clears interrupt state but leaves the sticky configuration
   always @(posedge aclk) begin
      if (!aresetn || hot_reset) begin
         irq_status_reg <= `RST_IRQ_STATUS;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn || hot_reset) begin
         irq_mask_reg <= `RST_IRQ_MASK;
      end else begin
         irq_mask_reg <= irq_mask_next;
      end
   end

   // new mask used at once, so a masked bit never lingers a cycle on irq
   always @(posedge aclk) begin
      if (!aresetn || hot_reset) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_status_next & irq_mask_next);
      end
   end

   assign irq = irq_reg;

   // ---------------- read path ----------------
   assign ar_hs = s_axi_arvalid & ~rvalid_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign rd_ok = addr_mapped(s_axi_araddr);

   // one word per register, reserved bits read as zero
   always @* begin
      ctrl_word = `ZERO_WORD;
      pend_word = `ZERO_WORD;
      pin_word = `ZERO_WORD;
      stat_word = `ZERO_WORD;
      mask_word = `ZERO_WORD;
      ctrl_word[`PORT_HI:0] = divert_ctrl_reg;
      pend_word[`FLD_PORT_HI:`FLD_PORT_LO] = pending;
      pin_word[`BIT_ALT_ENABLE] = alt_enable_reg;
      stat_word[`FLD_PORT_HI:`FLD_PORT_LO] = irq_status_reg;
      mask_word[`FLD_PORT_HI:`FLD_PORT_LO] = irq_mask_reg;
   end

   // unmapped addresses read zero and answer with an error code
   always @* begin
      rd_word = `ZERO_WORD;
      case (s_axi_araddr)
         `OFS_DIVERT_CTRL: rd_word = ctrl_word;
         `OFS_PENDING_STS: rd_word = pend_word;
         `OFS_PIN_CFG: rd_word = pin_word;
         `OFS_IRQ_STATUS: rd_word = stat_word;
         `OFS_IRQ_MASK: rd_word = mask_word;
         default: rd_word = `ZERO_WORD;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
      end else if (ar_hs) begin
         rvalid_reg <= 1'b1;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // data and code captured only at the address handshake, then held
   always @(posedge aclk) begin
      if (!aresetn) begin
         rdata_reg <= `ZERO_WORD;
         rresp_reg <= `RESP_OKAY;
      end else if (ar_hs) begin
         rdata_reg <= rd_word;
         rresp_reg <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule // event_signal_top

/* test/event_signal_props.sv */
// bus and pin checks for the event signalling top
// assumes only the top ports are visible; bound below
`timescale 1ns/1ps
`include "event_signal_defines.vh"
module event_signal_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`PORT_HI:`PORT_LO] port_event_req,
   input wire logic [`PORT_HI:`PORT_LO] std_notify,
   input wire logic gpio7_out,
   input wire logic gpio7_oe,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [`DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence aw_w; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
   sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
   std_path_a: assert property ((std_notify & ~port_event_req) == 7'h00)
      else $error("standard notify without request");
   pin_off_a: assert property (!gpio7_oe |-> !gpio7_out)
      else $error("pin level without enable");
   wr_lat_a: assert property (aw_w |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   wr_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   rd_hold_a: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer stuck");
   ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
   resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {`RESP_OKAY, `RESP_SLVERR})
      else $error("bad write response");
endmodule // event_signal_props
bind event_signal_top event_signal_props u_event_signal_props (.*);

/* test/event_sense_model.sv */
// system logic sensing the shared event pin
// assumes a pull-up on the pin and knows the programmed polarity
`timescale 1ns/1ps
module event_sense_model (
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic polarity_invert,
   output logic pin_level,
   output logic event_seen
);
   // undriven pin goes to the pull-up, never keeps the last value
   assign pin_level = pin_oe ? pin_out : 1'b1;
   assign event_seen = pin_oe & (polarity_invert ? pin_level : ~pin_level);
endmodule // event_sense_model

/* test/testbench.sv */
// self-checking bench for the event signalling block
// assumes the design, checker and pin model are compiled first
`timescale 1ns/1ps
module testbench;
   logic aclk = 0, aresetn = 0, hot_reset = 0, inv = 0;
   logic [7:1] req = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0] strb = 4'hf;
   wire [7:1] std_notify;
   wire pin_out, pin_oe, irq, awready, wready, bvalid, arready, rvalid, level, seen;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int n_errors = 0, checks_done = 0, cyc = 0;
   always #5 aclk = ~aclk;
   event_signal_top u_event_signal_top (.aclk(aclk), .aresetn(aresetn), .hot_reset(hot_reset),
      .port_event_req(req), .std_notify(std_notify), .gpio7_out(pin_out), .gpio7_oe(pin_oe), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   event_sense_model u_event_sense_model (.pin_out(pin_out), .pin_oe(pin_oe), .polarity_invert(inv),
      .pin_level(level), .event_seen(seen));
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   // each channel is judged and released at the rising edge that takes it
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic done;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 0;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            check(32'(bresp), 32'(r));
            bready <= 1'b0;
            done = 1;
         end
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      logic done;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 0;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            check(rdata, e);
            check(32'(rresp), 32'(r));
            rready <= 1'b0;
            done = 1;
         end
      end
   endtask
   task automatic settle;
      repeat (3) @(posedge aclk);
   endtask
   task automatic t_reset;
      rd(12'h450, 32'h0, 2'h0);
      rd(12'h454, 32'h0, 2'h0);
      rd(12'h470, 32'h0, 2'h2);
      check(32'(pin_oe), 32'h0);
   endtask
   task automatic t_divert;
      wr(12'h458, 32'h1, 2'h0);
      wr(12'h450, 32'hffffff02, 2'h0);
      rd(12'h450, 32'h2, 2'h0);
      wr(12'h460, 32'h2, 2'h0);
      rd(12'h460, 32'h2, 2'h0);
      req <= 7'h03;
      settle;
      check(32'(std_notify), 32'h2);
      check(32'(pin_oe), 32'h1);
      check(32'(pin_out), 32'h0);
      check(32'(seen), 32'h1);
      check(32'(irq), 32'h1);
      rd(12'h454, 32'h2, 2'h0);
      rd(12'h45c, 32'h2, 2'h0);
      req <= 7'h00;
      settle;
      check(32'(pin_out), 32'h1);
      wr(12'h45c, 32'h2, 2'h0);
      check(32'(irq), 32'h0);
      wr(12'h454, 32'hff, 2'h0);
      rd(12'h454, 32'h0, 2'h0);
   endtask
   task automatic t_polarity;
      wr(12'h450, 32'h3, 2'h0);
      inv <= 1'b1;
      settle;
      check(32'(pin_out), 32'h0);
      req <= 7'h01;
      settle;
      check(32'(pin_out), 32'h1);
      check(32'(seen), 32'h1);
      check(32'(irq), 32'h1);
      hot_reset <= 1'b1;
      @(posedge aclk);
      hot_reset <= 1'b0;
      rd(12'h450, 32'h3, 2'h0);
      check(32'(irq), 32'h0);
      rd(12'h45c, 32'h0, 2'h0);
      rd(12'h460, 32'h0, 2'h0);
   endtask
   // a write with lane 0 strobe low must leave the register alone
   task automatic t_strobe;
      strb <= 4'he;
      wr(12'h450, 32'h0, 2'h0);
      rd(12'h450, 32'h3, 2'h0);
      strb <= 4'hf;
   endtask
   task automatic t_alt_off;
      wr(12'h458, 32'h0, 2'h0);
      settle;
      check(32'(pin_oe), 32'h0);
      check(32'(pin_out), 32'h0);
      check(32'(level), 32'h1);
      req <= 7'h00;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_divert;
      t_polarity;
      t_strobe;
      t_alt_off;
      tally_and_finish;
   end
endmodule // testbench
